/* design/rtcw_value_windows.sv */
// Time and alarm value windows of the real-time clock, reached over AXI4-Lite.
//
// Notes on behaviour
// - Time pointer 11 shows the year: tens in bits 7-4, ones in 3-0.
// - The year word changes on write only while clock write enable is 1.
// - Time pointer 10 shows month: tens bit 12, ones digit bits 11-8.
// - Month/day word keeps day tens in bits 5-4, day ones in 3-0.
// - Time pointer 01 shows the weekday digit in bits 10-8.
// - Weekday/hours word keeps hour tens in bits 5-4, hour ones in 3-0.
// - Time pointer 00 shows minutes: tens bits 14-12, ones bits 11-8.
// - Minutes/seconds word keeps seconds tens in bits 6-4, ones in 3-0.
// - Time and alarm month/day and weekday/hours writes need write enable.
// - Alarm pointer picks alarm month/day, weekday/hours or minutes/seconds.
// - Bits outside the BCD fields ignore writes and read as zero.
`timescale 1ns/10ps
`default_nettype none
module rtcw_value_windows #(
  parameter int AW = rtcw_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // AXI4-Lite write channels
  input  wire logic [AW-1:0]             s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [AW-1:0]             s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Control state seen by the calendar logic
  output logic                           clock_write_enable,
  output logic [rtcw_pkg::PTR_W-1:0]     time_window_pointer,
  output logic [rtcw_pkg::PTR_W-1:0]     alarm_window_pointer
);
  import rtcw_pkg::*;

  if (AW < ADDR_W) begin : g_bad_aw
    $error("rtcw_value_windows: AW too narrow for the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  rtcw_wreq_t          wreq;
  logic                wreq_valid;
  logic [ADDR_W-1:0]   rd_addr;
  logic [15:0]         rd_word;

  rtcw_axil_port #(
    .AW (AW)
  ) u_port (
    .clk           (clk),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wreq          (wreq),
    .wreq_valid    (wreq_valid),
    .rd_addr       (rd_addr),
    .rd_word       (rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control word: write enable and the two window pointers

  logic                clock_write_enable_ff;
  logic [PTR_W-1:0]    time_ptr_ff;
  logic [PTR_W-1:0]    alarm_ptr_ff;
  logic [15:0]         ctrl_view;
  logic [15:0]         nxt_ctrl;

  assign ctrl_view = {6'h00, alarm_ptr_ff, 2'h0, time_ptr_ff, 3'h0, clock_write_enable_ff};
  assign nxt_ctrl  = rtcw_merge(ctrl_view, wreq.data[15:0], wreq.strb) & CTRL_MASK;

  always_ff @(posedge clk) begin
    if (reset) begin
      clock_write_enable_ff <= 1'b0;
      time_ptr_ff           <= PTR_MINSEC;
      alarm_ptr_ff          <= PTR_MINSEC;
    end else if (wreq_valid && wreq.addr == CTRL_OFF) begin
      clock_write_enable_ff <= nxt_ctrl[WREN_BIT];
      time_ptr_ff           <= nxt_ctrl[TPTR_LSB +: PTR_W];
      alarm_ptr_ff          <= nxt_ctrl[APTR_LSB +: PTR_W];
    end
  end

  assign clock_write_enable   = clock_write_enable_ff;
  assign time_window_pointer  = time_ptr_ff;
  assign alarm_window_pointer = alarm_ptr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Value word storage
  //
  // The words carry no reset on purpose: an RTC keeps its time across a
  // processor reset, so clearing it here would lose the calendar.

  logic [15:0]         time_words_ff  [TIME_WORDS];
  logic [15:0]         alarm_words_ff [ALARM_WORDS];
  logic                time_wr;
  logic                alarm_wr;
  logic                time_wr_ok;
  logic                alarm_wr_ok;
  logic [15:0]         time_view;
  logic [15:0]         alarm_view;
  logic [15:0]         nxt_time_word;
  logic [15:0]         nxt_alarm_word;

  assign time_wr  = wreq_valid && wreq.addr == TIME_OFF;
  assign alarm_wr = wreq_valid && wreq.addr == ALARM_OFF;

  // Only the minutes/seconds words are writable without the enable.
  assign time_wr_ok  = clock_write_enable_ff || time_ptr_ff == PTR_MINSEC;
  assign alarm_wr_ok = alarm_ptr_ff != PTR_YEAR
                       && (clock_write_enable_ff || alarm_ptr_ff == PTR_MINSEC);

  // Digits are stored as written; no range check, so software owns legality.
  assign nxt_time_word  = rtcw_merge(time_view, wreq.data[15:0], wreq.strb)
                          & rtcw_word_mask(time_ptr_ff);
  assign nxt_alarm_word = rtcw_merge(alarm_view, wreq.data[15:0], wreq.strb)
                          & rtcw_word_mask(alarm_ptr_ff);

  always_ff @(posedge clk) begin
    if (time_wr && time_wr_ok) begin
      time_words_ff[time_ptr_ff] <= nxt_time_word;
    end
  end

  always_ff @(posedge clk) begin
    if (alarm_wr && alarm_wr_ok) begin
      alarm_words_ff[alarm_ptr_ff] <= nxt_alarm_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window views and read mux

  always_comb begin
    unique case (time_ptr_ff)
      PTR_YEAR:   time_view = time_words_ff[PTR_YEAR] & MASK_YEAR;
      PTR_MTHDAY: time_view = time_words_ff[PTR_MTHDAY] & MASK_MTHDAY;
      PTR_WKHR:   time_view = time_words_ff[PTR_WKHR] & MASK_WKHR;
      PTR_MINSEC: time_view = time_words_ff[PTR_MINSEC] & MASK_MINSEC;
    endcase
  end

  // The alarm set has no year word; that pointer code reads as zero.
  always_comb begin
    unique case (alarm_ptr_ff)
      PTR_MTHDAY: alarm_view = alarm_words_ff[PTR_MTHDAY] & MASK_MTHDAY;
      PTR_WKHR:   alarm_view = alarm_words_ff[PTR_WKHR] & MASK_WKHR;
      PTR_MINSEC: alarm_view = alarm_words_ff[PTR_MINSEC] & MASK_MINSEC;
      PTR_YEAR:   alarm_view = MASK_NONE;
    endcase
  end

  always_comb begin
    unique case (rd_addr)
      CTRL_OFF:  rd_word = ctrl_view;
      TIME_OFF:  rd_word = time_view;
      ALARM_OFF: rd_word = alarm_view;
      default:   rd_word = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  //
  // A word counts as known once written, so checks never look at the
  // undefined power-up contents.

  logic [TIME_WORDS-1:0]  time_known_ff;
  logic [ALARM_WORDS-1:0] alarm_known_ff;
  logic                   rd_take;

  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk) begin
    if (reset) begin
      time_known_ff  <= '0;
      alarm_known_ff <= '0;
    end else begin
      if (time_wr && time_wr_ok) time_known_ff[time_ptr_ff] <= 1'b1;
      if (alarm_wr && alarm_wr_ok && alarm_ptr_ff != PTR_YEAR) begin
        alarm_known_ff[alarm_ptr_ff] <= 1'b1;
      end
    end
  end

  sequence s_time_read(logic [1:0] p);
    rd_take && rd_addr == TIME_OFF && time_ptr_ff == p;
  endsequence

  sequence s_locked_time_write(logic [1:0] p);
    time_wr && time_ptr_ff == p && !clock_write_enable_ff && time_known_ff[p];
  endsequence

  property p_year_view;
    @(posedge clk) disable iff (reset)
      s_time_read(PTR_YEAR) |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_year_view: assert property (p_year_view)
    else $error("year window shows bits above the year digits");

  property p_year_locked;
    @(posedge clk) disable iff (reset)
      s_locked_time_write(PTR_YEAR) |=> $stable(time_words_ff[PTR_YEAR]);
  endproperty
  a_year_locked: assert property (p_year_locked)
    else $error("year word changed without write enable");

  property p_month_view;
    @(posedge clk) disable iff (reset)
      s_time_read(PTR_MTHDAY) |=> s_axi_rvalid && s_axi_rdata[15:13] == 3'h0;
  endproperty
  a_month_view: assert property (p_month_view)
    else $error("month window shows bits above the month tens bit");

  property p_day_view;
    @(posedge clk) disable iff (reset)
      s_time_read(PTR_MTHDAY) |=> s_axi_rdata[7:6] == 2'h0;
  endproperty
  a_day_view: assert property (p_day_view)
    else $error("day window shows bits above the day tens digit");

  property p_weekday_view;
    @(posedge clk) disable iff (reset)
      s_time_read(PTR_WKHR) |=> s_axi_rvalid && s_axi_rdata[15:11] == 5'h00;
  endproperty
  a_weekday_view: assert property (p_weekday_view)
    else $error("weekday window shows bits above the weekday digit");

  property p_hour_view;
    @(posedge clk) disable iff (reset)
      s_time_read(PTR_WKHR) |=> s_axi_rdata[7:6] == 2'h0;
  endproperty
  a_hour_view: assert property (p_hour_view)
    else $error("hours window shows bits above the hour tens digit");

  property p_minsec_write;
    logic [15:0] d;
    @(posedge clk) disable iff (reset)
      (time_wr && time_ptr_ff == PTR_MINSEC && wreq.strb[1:0] == 2'h3, d = wreq.data[15:0])
        |=> time_words_ff[PTR_MINSEC] == (d & MASK_MINSEC);
  endproperty
  a_minsec_write: assert property (p_minsec_write)
    else $error("minutes/seconds write did not land without the enable");

  property p_sec_view;
    @(posedge clk) disable iff (reset)
      s_time_read(PTR_MINSEC) |=> s_axi_rdata[7] == 1'b0 && s_axi_rdata[15] == 1'b0;
  endproperty
  a_sec_view: assert property (p_sec_view)
    else $error("minutes/seconds window shows reserved bits");

  property p_alarm_locked;
    @(posedge clk) disable iff (reset)
      alarm_wr && !clock_write_enable_ff && alarm_ptr_ff != PTR_MINSEC
        && alarm_ptr_ff != PTR_YEAR && alarm_known_ff[alarm_ptr_ff]
        |=> $stable(alarm_view);
  endproperty
  a_alarm_locked: assert property (p_alarm_locked)
    else $error("alarm word changed without write enable");

  property p_alarm_select;
    @(posedge clk) disable iff (reset)
      rd_take && rd_addr == ALARM_OFF && alarm_ptr_ff == PTR_YEAR
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_alarm_select: assert property (p_alarm_select)
    else $error("alarm window shows data for an unused pointer code");

  property p_upper_zero;
    @(posedge clk) disable iff (reset)
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data carries bits above the 16-bit word");

  property p_ctrl_readback;
    logic [15:0] d;
    @(posedge clk) disable iff (reset)
      (wreq_valid && wreq.addr == CTRL_OFF && wreq.strb[1:0] == 2'h3, d = wreq.data[15:0])
        |=> ctrl_view == (d & CTRL_MASK) ##1 1'b1;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control word did not take the written value");

  property p_year_write;
    logic [15:0] d;
    @(posedge clk) disable iff (reset)
      (time_wr && time_ptr_ff == PTR_YEAR && clock_write_enable_ff && wreq.strb[1:0] == 2'h3,
       d = wreq.data[15:0])
        |=> time_words_ff[PTR_YEAR] == (d & MASK_YEAR);
  endproperty
  a_year_write: assert property (p_year_write)
    else $error("year write with the enable set did not land");

  // Software polls on these answers, so their one-cycle latency is part of the contract.
  property p_wr_answer;
    @(posedge clk) disable iff (reset)
      wreq_valid |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response did not follow the commit");

  property p_wr_refuse;
    @(posedge clk) disable iff (reset)
      wreq_valid && !rtcw_addr_known(wreq.addr) |=> s_axi_bresp == RESP_SLVERR;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse)
    else $error("write to an unmapped word was not refused");

  property p_rd_answer;
    @(posedge clk) disable iff (reset)
      rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data did not follow the address handshake");

endmodule
`default_nettype wire

/* pkg/rtcw_pkg.sv */
// Package for the time and alarm value windows: map, field masks, carriers and helpers.
`default_nettype none
package rtcw_pkg;

  // Register map, byte addresses on the AXI4-Lite port.
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFF    = 4'h0;
  localparam logic [3:0]  TIME_OFF    = 4'h4;
  localparam logic [3:0]  ALARM_OFF   = 4'h8;

  // Control word layout.
  localparam int          PTR_W       = 2;
  localparam int          WREN_BIT    = 0;
  localparam int          TPTR_LSB    = 4;
  localparam int          APTR_LSB    = 8;
  localparam logic [15:0] CTRL_MASK   = 16'h0331;

  // Window pointer codes.
  localparam logic [1:0]  PTR_MINSEC  = 2'h0;
  localparam logic [1:0]  PTR_WKHR    = 2'h1;
  localparam logic [1:0]  PTR_MTHDAY  = 2'h2;
  localparam logic [1:0]  PTR_YEAR    = 2'h3;
  localparam int          TIME_WORDS  = 4;
  localparam int          ALARM_WORDS = 3;

  // Bits that hold BCD digits in each word; all other bits read as zero.
  localparam logic [15:0] MASK_YEAR   = 16'h00ff;
  localparam logic [15:0] MASK_MTHDAY = 16'h1f3f;
  localparam logic [15:0] MASK_WKHR   = 16'h073f;
  localparam logic [15:0] MASK_MINSEC = 16'h7f7f;
  localparam logic [15:0] MASK_NONE   = 16'h0000;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } rtcw_wreq_t;

  function automatic logic [15:0] rtcw_word_mask(input logic [1:0] ptr);
    unique case (ptr)
      PTR_YEAR:   rtcw_word_mask = MASK_YEAR;
      PTR_MTHDAY: rtcw_word_mask = MASK_MTHDAY;
      PTR_WKHR:   rtcw_word_mask = MASK_WKHR;
      PTR_MINSEC: rtcw_word_mask = MASK_MINSEC;
    endcase
  endfunction

  function automatic logic rtcw_addr_known(input logic [ADDR_W-1:0] addr);
    rtcw_addr_known = (addr == CTRL_OFF) || (addr == TIME_OFF) || (addr == ALARM_OFF);
  endfunction

  // Byte-lane merge of a 16-bit register; only the two low lanes exist.
  function automatic logic [15:0] rtcw_merge(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [3:0]  strb);
    rtcw_merge = {strb[1] ? new_val[15:8] : old_val[15:8],
                  strb[0] ? new_val[7:0]  : old_val[7:0]};
  endfunction

endpackage
`default_nettype wire

/* design/rtcw_axil_port.sv */
// AXI4-Lite slave front end for the value windows.
`timescale 1ns/10ps
`default_nettype none
module rtcw_axil_port #(
  parameter int AW = rtcw_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Write channels
  input  wire logic [AW-1:0]             s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // Read channels
  input  wire logic [AW-1:0]             s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Register file side
  output rtcw_pkg::rtcw_wreq_t           wreq,
  output logic                           wreq_valid,
  output logic [rtcw_pkg::ADDR_W-1:0]    rd_addr,
  input  wire logic [15:0]               rd_word
);
  import rtcw_pkg::*;

  logic                aw_held_ff;
  logic                w_held_ff;
  logic [ADDR_W-1:0]   awaddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                rvalid_ff;
  logic [1:0]          rresp_ff;
  logic [31:0]         rdata_ff;

  // Address and data are taken independently; neither is taken while a response waits.
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign wreq_valid    = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wreq          = '{addr: awaddr_ff, data: wdata_ff, strb: wstrb_ff};
  assign rd_addr       = s_axi_araddr[ADDR_W-1:0];
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  always_ff @(posedge clk) begin
    if (reset || wreq_valid) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_held_ff <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_held_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) awaddr_ff <= s_axi_awaddr[ADDR_W-1:0];
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wreq_valid) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= rtcw_addr_known(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rtcw_addr_known(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= {16'h0000, rd_word};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the time and alarm value windows over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import rtcw_pkg::*;
  logic                clk;
  logic                reset;
  logic [ADDR_W-1:0]   awaddr;
  logic                awvalid;
  logic                awready;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic                bready;
  logic [ADDR_W-1:0]   araddr;
  logic                arvalid;
  logic                arready;
  logic [31:0]         rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  logic                rready;
  logic                cwe;
  logic [PTR_W-1:0]    tptr;
  logic [PTR_W-1:0]    aptr;
  int                  n_mismatch;
  int                  num_checks;
  int                  cycles;
  logic [15:0]         masks [4];
  logic [15:0]         pats  [4];

  rtcw_value_windows i_dut (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clock_write_enable(cwe), .time_window_pointer(tptr), .alarm_window_pointer(aptr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks. Handshakes are sampled at the falling edge, where the combinational
  // readies already hold the value that the next rising edge will see.
  task automatic wr_chk(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s,
                        input logic [1:0] exp_resp);
    logic aw_p;
    logic w_p;
    logic aw_t;
    logic w_t;
    logic done;
    logic [1:0] r;
    aw_p = 1'b1;
    w_p = 1'b1;
    done = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      aw_t = aw_p && awready;
      w_t = w_p && wready;
      done = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    bready <= 1'b0;
    @(posedge clk);
    `CHK(r, exp_resp)
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp_d, input logic [1:0] exp_r);
    logic ar_p;
    logic ar_t;
    logic done;
    logic [31:0] d;
    logic [1:0] r;
    ar_p = 1'b1;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ar_t = ar_p && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_t) begin
        arvalid <= 1'b0;
        ar_p = 1'b0;
      end
    end
    rready <= 1'b0;
    @(posedge clk);
    `CHK(d, {16'h0000, exp_d})
    `CHK(r, exp_r)
  endtask

  task automatic set_ctl(input logic we, input logic [1:0] tp, input logic [1:0] ap);
    logic [15:0] c;
    c = 16'h0000;
    c[WREN_BIT] = we;
    c[TPTR_LSB +: PTR_W] = tp;
    c[APTR_LSB +: PTR_W] = ap;
    wr_chk(CTRL_OFF, c, 4'h3, RESP_OKAY);
    rd_chk(CTRL_OFF, c, RESP_OKAY);
    `CHK({cwe, tptr, aptr}, {we, tp, ap})
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_time_fields();
    for (int p = 0; p < 4; p++) begin
      set_ctl(1'b1, 2'(p), 2'h0);
      wr_chk(TIME_OFF, 16'hffff, 4'hf, RESP_OKAY);
      rd_chk(TIME_OFF, masks[p], RESP_OKAY);
      wr_chk(TIME_OFF, pats[p], 4'h3, RESP_OKAY);
      rd_chk(TIME_OFF, pats[p] & masks[p], RESP_OKAY);
    end
  endtask

  // Only minutes/seconds stays writable with the enable off.
  task automatic t_time_lock();
    for (int p = 0; p < 4; p++) begin
      set_ctl(1'b0, 2'(p), 2'h0);
      wr_chk(TIME_OFF, 16'h0000, 4'h3, RESP_OKAY);
      rd_chk(TIME_OFF, (p == 0) ? 16'h0000 : pats[p] & masks[p], RESP_OKAY);
    end
    set_ctl(1'b1, 2'h0, 2'h0);
    wr_chk(TIME_OFF, 16'h1234, 4'h1, RESP_OKAY);
    rd_chk(TIME_OFF, 16'h0034, RESP_OKAY);
  endtask

  task automatic t_alarm();
    for (int p = 0; p < 4; p++) begin
      set_ctl(1'b1, 2'h0, 2'(p));
      wr_chk(ALARM_OFF, 16'hffff, 4'h3, RESP_OKAY);
      rd_chk(ALARM_OFF, (p == 3) ? MASK_NONE : masks[p], RESP_OKAY);
      wr_chk(ALARM_OFF, pats[p], 4'h3, RESP_OKAY);
      rd_chk(ALARM_OFF, (p == 3) ? MASK_NONE : pats[p] & masks[p], RESP_OKAY);
    end
    for (int p = 1; p < 3; p++) begin
      set_ctl(1'b0, 2'h0, 2'(p));
      wr_chk(ALARM_OFF, 16'h0000, 4'h3, RESP_OKAY);
      rd_chk(ALARM_OFF, pats[p] & masks[p], RESP_OKAY);
    end
  endtask

  // A reset in mid-run clears the control word but keeps the stored words.
  task automatic t_reset_keep();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_chk(CTRL_OFF, 16'h0000, RESP_OKAY);
    `CHK({cwe, tptr, aptr}, 5'h00)
    rd_chk(TIME_OFF, 16'h0034, RESP_OKAY);
    rd_chk(ALARM_OFF, pats[0] & masks[0], RESP_OKAY);
  endtask

  // An unmapped word is refused in both directions and returns zero.
  task automatic t_unmapped();
    wr_chk(4'hc, 16'hffff, 4'h3, RESP_SLVERR);
    rd_chk(4'hc, 16'h0000, RESP_SLVERR);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    reset = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    masks = '{MASK_MINSEC, MASK_WKHR, MASK_MTHDAY, MASK_YEAR};
    pats = '{16'h5959, 16'h0623, 16'h1231, 16'h0099};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_chk(CTRL_OFF, 16'h0000, RESP_OKAY);
    `CHK({cwe, tptr, aptr}, 5'h00)
    t_time_fields();
    t_time_lock();
    t_alarm();
    t_reset_keep();
    t_unmapped();
    wrap_up();
  end
endmodule
`default_nettype wire
